//--- osc_regs.sv
// Control bank of an eight-channel current sink driver with a serial slave port.
// Assumes a two-wire bus master on scl/sda and analog sinks driven from sinkOut.
//
// Overview of operation
// [R1] Register sink_on_off bit n-1 switches sink n on when set.
// [R2] Registers sink1_level to sink8_level hold six-bit multipliers; upper bits unused.
// [R3] Sink current equals step size times its multiplier.
// [R4] Multipliers above 50 act as 50.
// [R5] Register step_gain four-bit code gives step of 31.25 uA times code plus one.
// [R6] Enable rising edge loads defaults: on/off 0x00, each level 0x01, gain 0x08.
// [R7] Slave answers address 1110000; direction bit is the byte's LSB.
// [R8] Undervoltage indication disables the device; the code only forces all sinks off, serial port and registers stay active.
// [R9] Over-temperature indication disables all sinks until it clears.
// [R10] Outside system starts boost after driver, stops boost before sinks.
// [R11] Each access is one register address byte and one data byte; no increment.
// [R12] Pointer set by address-only write survives stop; later read returns it.
// [R13] General call ignored; seven-bit addressing only.
// [R14] Host drives the active-high enable pin to operate the device.
// [R15] Unused bits and unmapped addresses ignore writes and read zero.
// [R16] Sink carries current only when on and no protection indication.
`timescale 1ns/1ps
`include "osc_consts.svh"

module osc_regs (
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_b,
  input  wire logic                                  scl,
  input  wire logic                                  sdaIn,
  input  wire logic                                  enable,
  input  wire logic                                  undervoltageLockout,
  input  wire logic                                  overTemp,
  output logic                                       sdaOut,
  output logic                                       sdaOe_b,
  output osc_pkg::osc_sink_t [`OSC_NUM_SINKS-1:0]    sinkOut
);
  import osc_pkg::*;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  osc_pins_t                                    pinS;
  logic                                         sclPrev_reg;
  logic                                         sdaPrev_reg;
  logic                                         enPrev_reg;
  logic                                         sclRise;
  logic                                         sclFall;
  logic                                         startDet;
  logic                                         stopDet;
  logic                                         enRise;
  logic                                         gateOk;
  osc_state_t                                   state_reg;
  osc_state_t                                   state_next;
  logic [3:0]                                   bitCnt_reg;
  logic [3:0]                                   bitCnt_next;
  logic [7:0]                                   shift_reg;
  logic [7:0]                                   shift_next;
  logic [7:0]                                   ptr_reg;
  logic [7:0]                                   ptr_next;
  logic                                         rw_reg;
  logic                                         rw_next;
  logic                                         sdaOe_b_reg;
  logic                                         sdaOe_b_next;
  logic                                         wrEn;
  logic [7:0]                                   rdData;
  logic [2:0]                                   lvlIdx;
  logic [`OSC_NUM_SINKS-1:0]                    onOff_reg;
  logic [`OSC_NUM_SINKS-1:0]                    onOff_next;
  logic [`OSC_NUM_SINKS-1:0][`OSC_LVL_W-1:0]    level_reg;
  logic [`OSC_NUM_SINKS-1:0][`OSC_LVL_W-1:0]    level_next;
  logic [`OSC_GAIN_W-1:0]                       gain_reg;
  logic [`OSC_GAIN_W-1:0]                       gain_next;
  logic [`OSC_NUM_SINKS-1:0][`OSC_CUR_W-1:0]    calcCur;
  osc_sink_t [`OSC_NUM_SINKS-1:0]               sinkOut_reg;
  osc_sink_t [`OSC_NUM_SINKS-1:0]               sinkOut_next;

  // ----------------------------------------------------------------------------
  // Input synchronisation and edge detection
  // ----------------------------------------------------------------------------
  osc_pin_sync u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pinRaw  ({scl, sdaIn, enable, undervoltageLockout, overTemp}),
    .pinSync (pinS)
  );

  // Edges use the synchronised copy and its own one-cycle history.
  assign sclRise  = pinS.scl & ~sclPrev_reg;
  assign sclFall  = ~pinS.scl & sclPrev_reg;
  assign startDet = pinS.scl & sclPrev_reg & sdaPrev_reg & ~pinS.sda;
  assign stopDet  = pinS.scl & sclPrev_reg & ~sdaPrev_reg & pinS.sda;
  assign enRise   = pinS.en & ~enPrev_reg;
  // Any protection indication or a low enable pin removes sink current. Sinks also stay
  // off in the cycle of an enable rise, so stale settings never reach a sink.
  assign gateOk   = pinS.en & enPrev_reg & ~pinS.undervoltage_lockout & ~pinS.otemp; // [R6] [R8] [R9] [R14]

  // History flops; the bus ones start idle-high, enable low, so no false start after reset.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      enPrev_reg  <= 1'b0;
    end
    else
    begin
      sclPrev_reg <= pinS.scl;
      sdaPrev_reg <= pinS.sda;
      enPrev_reg  <= pinS.en;
    end
  end

  // ----------------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------------
  assign lvlIdx = 3'(ptr_reg[3:0] - 4'h1);

  // Unmapped addresses and unused upper bits read as zero.
  always_comb
  begin
    if (ptr_reg == `OSC_ADDR_ONOFF)
      rdData = onOff_reg;
    else if (ptr_reg <= `OSC_ADDR_LVL_LAST)
      rdData = {2'h0, level_reg[lvlIdx]}; // [R2]
    else if (ptr_reg == `OSC_ADDR_GAIN)
      rdData = {4'h0, gain_reg};
    else
      rdData = 8'h00; // [R15]
  end

  // ----------------------------------------------------------------------------
  // Serial slave engine
  // ----------------------------------------------------------------------------
  // ACK and read bits change only after a falling scl edge, so data is stable
  // while scl is high. The engine sleeps while enable is low.
  always_comb
  begin
    state_next   = state_reg;
    bitCnt_next  = bitCnt_reg;
    shift_next   = shift_reg;
    ptr_next     = ptr_reg;
    rw_next      = rw_reg;
    sdaOe_b_next = sdaOe_b_reg;
    wrEn         = 1'b0;
    if (!pinS.en || stopDet)
    begin
      state_next   = ST_IDLE; // Pointer is kept across a stop. [R12]
      sdaOe_b_next = 1'b1;
    end
    else if (startDet)
    begin
      state_next   = ST_ADDR;
      bitCnt_next  = 4'h0;
      sdaOe_b_next = 1'b1;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE, ST_IGNORE:
          state_next = state_reg;
        ST_ADDR, ST_REG, ST_DATA:
          if (sclRise)
          begin
            shift_next  = {shift_reg[6:0], pinS.sda};
            bitCnt_next = bitCnt_reg + 4'h1;
          end
          else if (sclFall && bitCnt_reg == `OSC_BITS_BYTE)
          begin
            bitCnt_next = 4'h0;
            if (state_reg == ST_ADDR)
            begin
              // General call and foreign addresses never match. [R13]
              if (shift_reg[7:1] == `OSC_SLAVE_ADDR) // [R7]
              begin
                rw_next      = shift_reg[0];
                sdaOe_b_next = 1'b0;
                state_next   = ST_ADDR_ACK;
              end
              else
                state_next = ST_IGNORE;
            end
            else if (state_reg == ST_REG)
            begin
              ptr_next     = shift_reg; // [R11]
              sdaOe_b_next = 1'b0;
              state_next   = ST_REG_ACK;
            end
            else
            begin
              wrEn         = 1'b1;
              sdaOe_b_next = 1'b0;
              state_next   = ST_DATA_ACK;
            end
          end
        ST_ADDR_ACK:
          if (sclFall)
          begin
            if (rw_reg)
            begin
              shift_next   = rdData; // [R12]
              sdaOe_b_next = rdData[7];
              state_next   = ST_RD;
            end
            else
            begin
              sdaOe_b_next = 1'b1;
              state_next   = ST_REG;
            end
          end
        ST_REG_ACK:
          if (sclFall)
          begin
            sdaOe_b_next = 1'b1;
            state_next   = ST_DATA;
          end
        ST_DATA_ACK:
          // A second data byte is not acknowledged: no auto increment.
          if (sclFall)
          begin
            sdaOe_b_next = 1'b1;
            state_next   = ST_IGNORE; // [R11]
          end
        ST_RD:
          if (sclFall)
          begin
            if (bitCnt_reg == `OSC_LAST_BIT)
            begin
              sdaOe_b_next = 1'b1;
              bitCnt_next  = 4'h0;
              state_next   = ST_RD_ACK;
            end
            else
            begin
              shift_next   = {shift_reg[6:0], 1'b0};
              sdaOe_b_next = shift_reg[6];
              bitCnt_next  = bitCnt_reg + 4'h1;
            end
          end
        ST_RD_ACK:
          if (sclRise)
            shift_next = {shift_reg[6:0], pinS.sda};
          else if (sclFall)
          begin
            if (!shift_reg[0])
            begin
              // Master ACK repeats the same register, pointer unchanged.
              shift_next   = rdData;
              sdaOe_b_next = rdData[7];
              state_next   = ST_RD;
            end
            else
              state_next = ST_IGNORE;
          end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_reg   <= ST_IDLE;
      bitCnt_reg  <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= `OSC_RST_PTR;
      rw_reg      <= 1'b0;
      sdaOe_b_reg <= 1'b1;
    end
    else
    begin
      state_reg   <= state_next;
      bitCnt_reg  <= bitCnt_next;
      shift_reg   <= shift_next;
      ptr_reg     <= ptr_next;
      rw_reg      <= rw_next;
      sdaOe_b_reg <= sdaOe_b_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------------------
  // Enable rising edge wins over a bus write in the same cycle.
  always_comb
  begin
    onOff_next = onOff_reg;
    level_next = level_reg;
    gain_next  = gain_reg;
    if (enRise)
    begin
      onOff_next = `OSC_RST_ONOFF; // [R6]
      level_next = {`OSC_NUM_SINKS{`OSC_RST_LEVEL}};
      gain_next  = `OSC_RST_GAIN;
    end
    else if (wrEn)
    begin
      if (ptr_reg == `OSC_ADDR_ONOFF)
        onOff_next = shift_reg; // [R1]
      else if (ptr_reg <= `OSC_ADDR_LVL_LAST)
        level_next[lvlIdx] = shift_reg[`OSC_LVL_W-1:0]; // [R2] [R15]
      else if (ptr_reg == `OSC_ADDR_GAIN)
        gain_next = shift_reg[`OSC_GAIN_W-1:0]; // [R5] [R15]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      onOff_reg <= `OSC_RST_ONOFF;
      level_reg <= {`OSC_NUM_SINKS{`OSC_RST_LEVEL}};
      gain_reg  <= `OSC_RST_GAIN;
    end
    else
    begin
      onOff_reg <= onOff_next;
      level_reg <= level_next;
      gain_reg  <= gain_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Sink outputs
  // ----------------------------------------------------------------------------
  osc_sink_calc u_calc (
    .level   (level_reg),
    .gain    (gain_reg),
    .current (calcCur)
  );

  // Each sink is gated by its on bit and the protection indications.
  genvar s;
  generate
    for (s = 0; s < `OSC_NUM_SINKS; s = s + 1)
    begin : g_out
      assign sinkOut_next[s].on      = onOff_reg[s] & gateOk; // [R1] [R16]
      assign sinkOut_next[s].current = (onOff_reg[s] & gateOk) ? calcCur[s] : '0; // [R16]
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      sinkOut_reg <= '0;
    else
      sinkOut_reg <= sinkOut_next;
  end

  assign sinkOut = sinkOut_reg;
  assign sdaOe_b = sdaOe_b_reg;
  // Open-drain line: the driven level is always low.
  assign sdaOut  = 1'b0;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  logic [`OSC_CUR_W-1:0] expCur0;
  assign expCur0 = `OSC_CUR_W'(`OSC_CUR_W'(level_reg[0]) * (`OSC_CUR_W'(gain_reg) + 10'h001));

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_prot_off: assert property ((pinS.undervoltage_lockout || pinS.otemp) |=> sinkOut_reg == '0) // [R8] [R9]
    else $error("Sink active during protection indication.");
  a_onoff_gate: assert property (gateOk && !onOff_reg[0] |=> !sinkOut_reg[0].on) // [R1] [R16]
    else $error("Sink one on while its bit is clear.");
  a_cur_formula: assert property (gateOk && onOff_reg[0] && level_reg[0] <= `OSC_LEVEL_MAX
    |=> sinkOut_reg[0].current == $past(expCur0)) // [R3] [R5]
    else $error("Sink one current not step times multiplier.");
  a_cur_clamp: assert property (sinkOut_reg[0].current <= `OSC_CUR_MAX) // [R4]
    else $error("Sink one current above clamp.");
  a_enable_defaults: assert property (enRise |=> onOff_reg == `OSC_RST_ONOFF
    && gain_reg == `OSC_RST_GAIN && level_reg[7] == `OSC_RST_LEVEL) // [R6]
    else $error("Defaults not loaded on enable rise.");
  a_addr_match: assert property (state_reg == ST_ADDR_ACK
    |-> shift_reg[7:1] == `OSC_SLAVE_ADDR && !sdaOe_b_reg) // [R7] [R13]
    else $error("Acknowledged a foreign address.");
  a_ptr_hold: assert property (state_reg == ST_IDLE || state_reg == ST_DATA
    |=> $stable(ptr_reg)) // [R11] [R12]
    else $error("Pointer moved outside the address byte.");
  a_read_load: assert property (state_reg == ST_ADDR_ACK && rw_reg && sclFall
    && pinS.en && !startDet && !stopDet |=> shift_reg == $past(rdData)) // [R12]
    else $error("Read byte not taken from the pointed register.");
  a_unmapped_zero: assert property (ptr_reg > `OSC_ADDR_GAIN |-> rdData == 8'h00) // [R15]
    else $error("Unmapped address reads non-zero.");

  c_write_done: cover property (state_reg == ST_DATA_ACK);
  c_read_done: cover property (state_reg == ST_RD_ACK ##1 state_reg == ST_RD_ACK);
  c_prot_hit: cover property (pinS.otemp && onOff_reg != '0);

endmodule

//--- osc_consts.svh
// Constants of the eight-channel sink control bank: addresses, defaults, widths.
// Assumes it is included by bare name wherever the constants are needed.
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define OSC_ADDR_ONOFF    8'h00
`define OSC_ADDR_LVL_LAST 8'h08
`define OSC_ADDR_GAIN     8'h09

// ----------------------------------------------------------------------------
// Defaults loaded on reset; on/off, level and gain also on the enable rising edge
// ----------------------------------------------------------------------------
`define OSC_RST_ONOFF 8'h00
`define OSC_RST_LEVEL 6'h01
`define OSC_RST_GAIN  4'h8
`define OSC_RST_PTR   8'h00
`define OSC_PIN_IDLE  5'h18 // Synchroniser reset: clock and data high, other pins low.

// ----------------------------------------------------------------------------
// Field widths and limits
// ----------------------------------------------------------------------------
`define OSC_NUM_SINKS 8
`define OSC_LVL_W     6
`define OSC_GAIN_W    4
`define OSC_CUR_W     10
`define OSC_LEVEL_MAX 6'h32
`define OSC_CUR_MAX   10'h320
`define OSC_NUM_PINS  5

// ----------------------------------------------------------------------------
// Serial bus framing
// ----------------------------------------------------------------------------
`define OSC_SLAVE_ADDR 7'h70
`define OSC_BITS_BYTE  4'h8
`define OSC_LAST_BIT   4'h7

`endif

//--- osc_pkg.sv
// Types shared by the sink control bank: pin bundle, sink output, bus states.
// Assumes osc_consts.svh is reachable on the include path.
`include "osc_consts.svh"

package osc_pkg;

  // Synchronised external inputs travel together.
  typedef struct packed {
    logic scl;
    logic sda;
    logic en;
    logic undervoltage_lockout;
    logic otemp;
  } osc_pins_t;

  // One sink: active flag and target current in 31.25 uA units.
  typedef struct packed {
    logic                  on;
    logic [`OSC_CUR_W-1:0] current;
  } osc_sink_t;

  // Serial slave states, Gray coded along the write path.
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_REG      = 4'h2,
    ST_REG_ACK  = 4'h6,
    ST_DATA     = 4'h7,
    ST_DATA_ACK = 4'h5,
    ST_RD       = 4'h4,
    ST_RD_ACK   = 4'hC,
    ST_IGNORE   = 4'hD
  } osc_state_t;

endpackage

//--- osc_pin_sync.sv
// Two-stage synchronisers for every pin that enters the system clock domain.
// Assumes raw inputs are asynchronous to clk_sys; the first stage feeds only the second.
`timescale 1ns/1ps
`include "osc_consts.svh"

module osc_pin_sync (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire logic [`OSC_NUM_PINS-1:0]  pinRaw,
  output osc_pkg::osc_pins_t             pinSync
);
  import osc_pkg::*;

  logic [`OSC_NUM_PINS-1:0] meta_reg;
  logic [`OSC_NUM_PINS-1:0] meta_next;
  logic [`OSC_NUM_PINS-1:0] stable_reg;
  logic [`OSC_NUM_PINS-1:0] stable_next;

  // ----------------------------------------------------------------------------
  // Per-pin stage chain.
  // ----------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `OSC_NUM_PINS; i = i + 1)
    begin : g_pin
      // Each stage copies the one before it; only the second stage is read outside.
      always_comb
      begin
        meta_next[i]   = pinRaw[i];
        stable_next[i] = meta_reg[i];
      end
    end
  endgenerate

  // Registers only; reset parks the bus lines high, as an idle bus is, so no false edge follows.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      meta_reg   <= `OSC_PIN_IDLE;
      stable_reg <= `OSC_PIN_IDLE;
    end
    else
    begin
      meta_reg   <= meta_next;
      stable_reg <= stable_next;
    end
  end

  assign pinSync = osc_pins_t'(stable_reg);

endmodule

//--- osc_sink_calc.sv
// Per-sink current computation: clamped multiplier times decoded step size.
// Assumes register values are stable in clk_sys; pure combinational logic.
`timescale 1ns/1ps
`include "osc_consts.svh"

module osc_sink_calc (
  input  wire logic [`OSC_NUM_SINKS-1:0][`OSC_LVL_W-1:0] level,
  input  wire logic [`OSC_GAIN_W-1:0]                    gain,
  output logic      [`OSC_NUM_SINKS-1:0][`OSC_CUR_W-1:0] current
);
  import osc_pkg::*;

  logic [`OSC_CUR_W-1:0] stepUnits;

  // Step size is gain code plus one, in 31.25 uA units.
  assign stepUnits = `OSC_CUR_W'(gain) + `OSC_CUR_W'(1); // [R5]

  genvar i;
  generate
    for (i = 0; i < `OSC_NUM_SINKS; i = i + 1)
    begin : g_sink
      logic [`OSC_LVL_W-1:0] clamped;
      // Codes above the maximum act as the maximum.
      assign clamped = (level[i] > `OSC_LEVEL_MAX) ? `OSC_LEVEL_MAX : level[i]; // [R4]
      // Product fits: 50 times 16 is 800, below 1024.
      assign current[i] = `OSC_CUR_W'(`OSC_CUR_W'(clamped) * stepUnits); // [R3]
    end
  endgenerate

endmodule

//--- osc_host_model.sv
// Two-wire bus master model that drives the sink control bank.
// Assumes the bench resolves the open-drain data wire into sdaWire.
`timescale 1ns/1ps

module osc_host_model (
  input  wire logic       clk_sys,
  input  wire logic       sdaWire,
  output logic            scl,
  output logic            sdaLow,
  output logic [7:0]      rdData,
  output logic            rdValid
);
  // The bus idles released; scl only moves inside frames.
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
    rdData = 8'h00;
    rdValid = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Data changes mid-low and is sampled late in the high phase, clear of the sync delay.
  task automatic xbit(input logic b, output logic r);
    sdaLow <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    r = sdaWire;
    tick(1);
    scl <= 1'b0;
    tick(2);
  endtask

  // Eight bits MSB first, then the acknowledge slot.
  task automatic xbyte(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                       output logic ack);
    for (int i = 7; i >= 0; i--) xbit(tx[i], rx[i]);
    xbit(ai, ack);
  endtask

  task automatic start_c;
    sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic stop_c;
    sdaLow <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b0;
    tick(6);
  endtask

  // Write frame: device byte, one register byte, one or two data bytes.
  task automatic wr(input logic [7:0] dev, input logic [7:0] ra, input logic [15:0] d,
                    input logic two, output logic ack);
    logic [7:0] rx;
    logic       a;
    start_c;
    xbyte(dev, 1'b1, rx, ack);
    xbyte(ra, 1'b1, rx, a);
    if (two) xbyte(d[15:8], 1'b1, rx, a);
    xbyte(d[7:0], 1'b1, rx, a);
    stop_c;
  endtask

  // Stop-separated read: the pointer is set, the bus is freed, then one byte is read.
  task automatic rd(input logic [7:0] ra);
    logic [7:0] rx;
    logic       a;
    start_c;
    xbyte(8'hE0, 1'b1, rx, a);
    xbyte(ra, 1'b1, rx, a);
    stop_c;
    start_c;
    xbyte(8'hE1, 1'b1, rx, a);
    xbyte(8'hFF, 1'b1, rx, a);
    stop_c;
    rdData <= rx;
    rdValid <= 1'b1;
    tick(1);
    rdValid <= 1'b0;
  endtask
endmodule

//--- octal_sink_ctrl_regs_tb_top.sv
// Self-checking bench for the sink control bank behind its serial port.
// Assumes osc_host_model plays the bus master; the data wire is resolved here.
`timescale 1ns/1ps

module octal_sink_ctrl_regs_tb_top;
  import osc_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst_b, enable, undervoltage_lockout, otemp, scl, sdaLow, sdaOut, sdaOe_b, rdValid, ack;
  logic [7:0]        rdData, onM, gainM, v;
  logic [7:0]        lvlM [1:8];
  osc_sink_t [7:0]   sinkOut;
  logic [7:0]        expQ [$];
  int                err_total = 0;
  int                comparisons = 0;
  // Stands for the external boost supply switch that the system sequences.
  logic              boostOn;
  // Pull-up wire: low when either party pulls it.
  wire               sdaWire = ~sdaLow & (sdaOe_b | sdaOut);

  always #5 clk_sys = ~clk_sys;

  osc_regs i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .scl(scl), .sdaIn(sdaWire),
    .enable(enable), .undervoltageLockout(undervoltage_lockout), .overTemp(otemp), .sdaOut(sdaOut),
    .sdaOe_b(sdaOe_b), .sinkOut(sinkOut));
  osc_host_model i_host (.clk_sys(clk_sys), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow),
    .rdData(rdData), .rdValid(rdValid));

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Each returned byte is matched against the oldest noted expectation.
  always @(posedge clk_sys)
    if (rdValid === 1'b1) chk({3'h0, rdData}, expQ.pop_front());

  task automatic rdchk(input logic [7:0] ra, input logic [7:0] e);
    expQ.push_back(e);
    i_host.rd(ra);
  endtask

  // The mirror keeps only the bits that the bank stores.
  task automatic wrm(input logic [7:0] ra, input logic [7:0] d);
    i_host.wr(8'hE0, ra, {8'h00, d}, 1'b0, ack);
    chk({10'h000, ack}, 11'h000);
    if (ra == 8'h00) onM = d;
    else if (ra <= 8'h08) lvlM[ra] = d & 8'h3F;
    else if (ra == 8'h09) gainM = d & 8'h0F;
  endtask

  task automatic setdef;
    onM = 8'h00;
    gainM = 8'h08;
    for (int i = 1; i < 9; i++) lvlM[i] = 8'h01;
  endtask

  // Waits out the two-flop sync and the output flop before comparing.
  task automatic sinkchk;
    logic [9:0] cur;
    repeat (5) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      cur = (lvlM[i+1] > 8'h32 ? 10'h032 : {2'h0, lvlM[i+1]}) * ({6'h00, gainM[3:0]} + 10'h001);
      chk(sinkOut[i], (onM[i] & enable & ~undervoltage_lockout & ~otemp) ? {1'b1, cur} : 11'h000);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run of about 17k cycles.
  initial
  begin
    #800000;
    err_total++;
    stop_test;
  end

  initial
  begin
    rst_b <= 1'b0;
    enable <= 1'b1;
    undervoltage_lockout <= 1'b0;
    otemp <= 1'b0;
    boostOn <= 1'b0;
    v = 8'($urandom(32'hBD46));
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk_sys);
    // The boost supply follows the driver in the start-up sequence.
    boostOn <= 1'b1;
    setdef;
    for (int a = 0; a < 11; a++)
      rdchk(a[7:0], a == 0 ? 8'h00 : a < 9 ? 8'h01 : a == 9 ? 8'h08 : 8'h00);
    $display("defaults test done");
    for (int a = 0; a < 10; a++)
    begin
      v = 8'($urandom);
      wrm(a[7:0], v);
      rdchk(a[7:0], a == 0 ? onM : a < 9 ? lvlM[a] : gainM);
    end
    wrm(8'hFF, 8'hFF);
    rdchk(8'hFF, 8'h00);
    $display("readback test done");
    wrm(8'h00, 8'hFF);
    wrm(8'h01, 8'h3F);
    wrm(8'h02, 8'h32);
    for (int g = 0; g < 16; g++)
    begin
      wrm(8'h09, g[7:0]);
      sinkchk;
    end
    $display("current test done");
    i_host.wr(8'hE2, 8'h00, 16'h0000, 1'b0, ack);
    chk({10'h000, ack}, 11'h001);
    i_host.wr(8'h00, 8'h00, 16'h0000, 1'b0, ack);
    chk({10'h000, ack}, 11'h001);
    i_host.wr(8'hE0, 8'h03, 16'h1122, 1'b1, ack);
    lvlM[3] = 8'h11;
    rdchk(8'h00, onM);
    rdchk(8'h03, 8'h11);
    rdchk(8'h04, lvlM[4]);
    $display("addressing test done");
    for (int p = 0; p < 3; p++)
    begin
      @(posedge clk_sys);
      undervoltage_lockout <= (p == 0);
      otemp <= (p == 1);
      sinkchk;
    end
    // The boost supply goes down before the sinks are switched off.
    boostOn <= 1'b0;
    @(posedge clk_sys);
    enable <= 1'b0;
    sinkchk;
    @(posedge clk_sys);
    enable <= 1'b1;
    setdef;
    sinkchk;
    boostOn <= 1'b1;
    rdchk(8'h09, 8'h08);
    rdchk(8'h05, 8'h01);
    $display("protection test done");
    stop_test;
  end
endmodule
